// ===== clk_src_sel.v
// System clock source selector with internal oscillator control; glitch-free except when ST_LOW falls back to ST_START
`include "clk_src_sel_regs.vh"
module clk_src_sel (
  input wire clk, // 200 MHz sampling clock
  input wire reset, // Synchronous, active high
  input wire [1:0] default_clock_cfg, // Configuration field, static
  input wire ctrl_wr, // Write strobe for the control fields
  input wire [3:0] wr_freq_sel, // New internal_freq_select value
  input wire [1:0] wr_clk_sel, // New sys_clk_select_field value
  input wire watchdog_enable, // Watchdog needs the slow oscillator
  input wire power_up_timer_active, // Power-up timer needs the slow oscillator
  input wire clock_out_pin_select, // 1: clock output pin drives system clock
  input wire gpio_out, // GPIO data for the clock output pin
  input wire gpio_oe, // GPIO enable for the clock output pin
  input wire secondary_osc_ready, // Ready indication from the timer block
  input wire ext_clock_in_pin, // External logic level clock
  input wire crystal_osc_in, // Secondary crystal oscillator output
  input wire slow_osc_in, // Slow internal oscillator output
  input wire fast_osc_in, // Fast internal oscillator output
  output reg sys_clk_q, // Selected system clock level
  output reg fast_osc_enable_q, // Run request to fast oscillator
  output reg slow_osc_enable_q, // Run request to slow oscillator
  output reg [3:0] internal_freq_select_q, // Frequency select readback
  output reg [1:0] sys_clk_select_field_q, // Clock select readback
  output reg fast_osc_ready_flag_q, // Fast oscillator ready
  output reg fast_osc_stable_flag_q, // Fast oscillator stable
  output reg slow_osc_ready_flag_q, // Slow oscillator ready
  output reg secondary_osc_ready_flag_q, // Secondary oscillator ready
  output reg running_external_q, // System clock from external clock
  output reg switch_busy_q, // Clock switch in progress
  output reg slow_timebase_q, // Slow time base for power-up and watchdog timers
  output reg ext_pin_is_gpio_q, // External clock pin free for GPIO
  output reg clock_out_pin_o, // Clock output pin data
  output reg clock_out_pin_oe // Clock output pin enable
);

  localparam [31:0] FAST_START_FULL = `FAST_START_CYC;
  localparam [31:0] FAST_STABLE_FULL = `FAST_STABLE_CYC;
  localparam [11:0] FAST_START_CYC = FAST_START_FULL[11:0];
  localparam [11:0] FAST_STABLE_CYC = FAST_STABLE_FULL[11:0];

  // Bit order in the sync vectors: ext, crystal, slow, fast
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] prev_q;
  reg [8:0] fast_div_q;
  reg [11:0] fast_cnt_q;
  reg slow_seen_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [1:0] cur_src_q;
  reg [3:0] cur_exp_q;
  reg [1:0] tgt_src_p_q;
  reg [3:0] tgt_exp_p_q;
  reg tgt_lvl_p_q;
  reg [1:0] ext_cnt_q;
  reg [10:0] sec_cnt_q;
  reg dly_ok;
  reg fast_en_d;
  reg slow_en_d;

  // Postscaler exponent: output is fast oscillator divided by 2**exp
  function [3:0] fdiv_exp;
    input [3:0] f;
    begin
      case (f)
        4'hf: fdiv_exp = 4'h0;
        4'he: fdiv_exp = 4'h1;
        4'hd: fdiv_exp = 4'h2;
        4'hc: fdiv_exp = 4'h3;
        4'hb: fdiv_exp = 4'h4;
        4'ha: fdiv_exp = 4'h5;
        4'h9: fdiv_exp = 4'h6;
        4'h8: fdiv_exp = 4'h7;
        4'h7: fdiv_exp = 4'h5;
        4'h6: fdiv_exp = 4'h6;
        4'h5: fdiv_exp = 4'h7;
        4'h4: fdiv_exp = 4'h8;
        default: fdiv_exp = 4'h9;
      endcase
    end
  endfunction

  // Source that the current settings ask for
  function [1:0] src_of;
    input [1:0] sys_clk_select_field;
    input [1:0] cfg;
    input [3:0] f;
    begin
      if (sys_clk_select_field[1] || (sys_clk_select_field == `SEL_CONFIGURED && cfg == `CFG_INTERNAL))
        src_of = (f[3:1] == 3'h0) ? `SRC_SLOW : `SRC_FAST;
      else if (sys_clk_select_field == `SEL_SECONDARY)
        src_of = `SRC_SEC;
      else
        src_of = `SRC_EXT;
    end
  endfunction

  // Level of a source, postscaled when it is the fast oscillator
  function lvl_of;
    input [1:0] s;
    input [3:0] e;
    input [3:0] sy;
    input [8:0] dv;
    begin
      case (s)
        `SRC_EXT: lvl_of = sy[0];
        `SRC_SEC: lvl_of = sy[1];
        `SRC_SLOW: lvl_of = sy[2];
        default: lvl_of = (e == 4'h0) ? sy[3] : dv[e - 4'h1];
      endcase
    end
  endfunction

  wire [1:0] tgt_src = src_of(sys_clk_select_field_q, default_clock_cfg, internal_freq_select_q);
  wire [3:0] tgt_exp = (tgt_src == `SRC_FAST) ? fdiv_exp(internal_freq_select_q) : 4'h0;
  wire [1:0] rst_src = src_of(`SEL_CONFIGURED, default_clock_cfg, `FREQ_RESET);
  wire [3:0] rst_exp = (rst_src == `SRC_FAST) ? fdiv_exp(`FREQ_RESET) : 4'h0;
  wire cur_lvl = lvl_of(cur_src_q, cur_exp_q, sync2_q, fast_div_q);
  wire tgt_lvl = lvl_of(tgt_src, tgt_exp, sync2_q, fast_div_q);
  wire tgt_same = (tgt_src == cur_src_q) && (tgt_exp == cur_exp_q);
  // A new target in this cycle has no valid edge history yet
  wire tgt_chg = (tgt_src != tgt_src_p_q) || (tgt_exp != tgt_exp_p_q);
  wire tgt_rise = tgt_lvl && !tgt_lvl_p_q && !tgt_chg;
  wire [3:0] rise = sync2_q & ~prev_q;
  wire freq_is_slow = (internal_freq_select_q[3:1] == 3'h0);
  wire fast_rdy = fast_osc_enable_q && (fast_cnt_q >= FAST_START_CYC);
  wire fast_stb = fast_osc_enable_q && (fast_cnt_q >= FAST_STABLE_CYC);
  wire slow_rdy = slow_osc_enable_q && slow_seen_q;
  wire switching = (state_q != `ST_RUN);

  // Start-up wait per target; a running internal oscillator is already ready
  always @*
  begin
    case (tgt_src)
      `SRC_FAST: dly_ok = fast_rdy;
      `SRC_SLOW: dly_ok = slow_rdy;
      `SRC_EXT: dly_ok = (ext_cnt_q == `EXT_SWITCH_EDGES);
      default: dly_ok = (sec_cnt_q == `SEC_SWITCH_EDGES);
    endcase
  end

  always @*
  begin
    fast_en_d = (!freq_is_slow && (default_clock_cfg == `CFG_EXT_HIGH || sys_clk_select_field_q[1]))
      || cur_src_q == `SRC_FAST || (switching && tgt_src == `SRC_FAST);
    // Slow drops once neither the clock path nor the timers use it
    slow_en_d = (freq_is_slow && sys_clk_select_field_q[1]) || watchdog_enable
      || power_up_timer_active || cur_src_q == `SRC_SLOW || (switching && tgt_src == `SRC_SLOW);
  end

  always @*
  begin
    state_d = state_q;
    case (state_q)
      `ST_RUN:
      begin
        if (!tgt_same)
          state_d = `ST_START;
      end
      `ST_START:
      begin
        if (tgt_same)
          state_d = `ST_RUN;
        else if (dly_ok)
          state_d = `ST_FALL;
      end
      `ST_FALL:
      begin
        if (!dly_ok)
          state_d = `ST_START;
        else if (!cur_lvl)
          state_d = `ST_LOW;
      end
      `ST_LOW:
      begin
        if (!dly_ok && !tgt_same)
          state_d = `ST_START;
        else if (tgt_rise)
          state_d = `ST_RUN;
      end
      default: state_d = `ST_RUN;
    endcase
  end

  // Oscillator inputs are asynchronous; second stage is the first one read
  always @(posedge clk)
  begin
    if (reset)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
    end
    else
    begin
      sync1_q <= {fast_osc_in, slow_osc_in, crystal_osc_in, ext_clock_in_pin};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Oscillator start-up tracking and postscaler
  always @(posedge clk)
  begin
    if (reset)
    begin
      fast_div_q <= 9'h000;
      fast_cnt_q <= 12'h000;
      slow_seen_q <= 1'b0;
      fast_osc_enable_q <= 1'b0;
      slow_osc_enable_q <= 1'b0;
      slow_timebase_q <= 1'b0;
    end
    else
    begin
      fast_osc_enable_q <= fast_en_d;
      slow_osc_enable_q <= slow_en_d;
      slow_timebase_q <= sync2_q[2];
      if (rise[3])
        fast_div_q <= fast_div_q + 9'h001;
      if (!fast_osc_enable_q)
        fast_cnt_q <= 12'h000;
      else if (fast_cnt_q < FAST_STABLE_CYC)
        fast_cnt_q <= fast_cnt_q + 12'h001;
      if (!slow_osc_enable_q)
        slow_seen_q <= 1'b0;
      else if (rise[2])
        slow_seen_q <= 1'b1;
    end
  end

  // Switch sequencer; the output follows whole clock phases, but resumes the current clock mid-phase when ST_LOW falls back to ST_START
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= `ST_RUN;
      cur_src_q <= rst_src;
      cur_exp_q <= rst_exp;
      tgt_src_p_q <= rst_src;
      tgt_exp_p_q <= rst_exp;
      tgt_lvl_p_q <= 1'b0;
      ext_cnt_q <= 2'h0;
      sec_cnt_q <= 11'h000;
      sys_clk_q <= 1'b0;
      switch_busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tgt_src_p_q <= tgt_src;
      tgt_exp_p_q <= tgt_exp;
      tgt_lvl_p_q <= tgt_lvl;
      switch_busy_q <= (state_d != `ST_RUN);
      // Edge counts restart whenever the target moves
      if (state_q == `ST_RUN || tgt_chg)
      begin
        ext_cnt_q <= 2'h0;
        sec_cnt_q <= 11'h000;
      end
      else
      begin
        if (rise[0] && ext_cnt_q != `EXT_SWITCH_EDGES)
          ext_cnt_q <= ext_cnt_q + 2'h1;
        if (rise[1] && sec_cnt_q != `SEC_SWITCH_EDGES)
          sec_cnt_q <= sec_cnt_q + 11'h001;
      end
      // No timeout: a stopped source simply freezes the system clock
      if (state_q == `ST_LOW && state_d == `ST_RUN)
      begin
        cur_src_q <= tgt_src;
        cur_exp_q <= tgt_exp;
        sys_clk_q <= 1'b1;
      end
      else if (state_d == `ST_LOW || state_q == `ST_LOW)
        sys_clk_q <= 1'b0;
      else
        sys_clk_q <= cur_lvl;
    end
  end

  // Control fields and status; status is frozen while a switch is pending
  always @(posedge clk)
  begin
    if (reset)
    begin
      internal_freq_select_q <= `FREQ_RESET;
      sys_clk_select_field_q <= `SEL_CONFIGURED;
      fast_osc_ready_flag_q <= 1'b0;
      fast_osc_stable_flag_q <= 1'b0;
      slow_osc_ready_flag_q <= 1'b0;
      secondary_osc_ready_flag_q <= 1'b0;
      running_external_q <= 1'b0;
      ext_pin_is_gpio_q <= 1'b0;
      clock_out_pin_o <= 1'b0;
      clock_out_pin_oe <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        internal_freq_select_q <= wr_freq_sel;
        sys_clk_select_field_q <= wr_clk_sel;
      end
      if (!switching)
      begin
        fast_osc_ready_flag_q <= fast_rdy;
        fast_osc_stable_flag_q <= fast_stb;
        slow_osc_ready_flag_q <= slow_rdy;
        secondary_osc_ready_flag_q <= secondary_osc_ready;
        running_external_q <= (cur_src_q == `SRC_EXT);
        ext_pin_is_gpio_q <= (cur_src_q != `SRC_EXT);
      end
      if (clock_out_pin_select)
      begin
        clock_out_pin_o <= sys_clk_q;
        clock_out_pin_oe <= 1'b1;
      end
      else
      begin
        clock_out_pin_o <= gpio_out;
        clock_out_pin_oe <= gpio_oe;
      end
    end
  end

endmodule

// ===== clk_src_sel_regs.vh
// Constants for the system clock source selector
// Function
// - Default config 11/10/01 selects external clock high, medium or low power range.
// - External clock runs with no added start-up delay after reset or wake.
// - Fully static logic; a stopped clock halts everything, state kept.
// - After reset the system clock follows the default clock configuration source.
// - Software clock select moves clock to secondary, configured or internal source.
// - Internal clock frees input pin; output pin is clock or GPIO by select bit.
// - Fast oscillator on when high frequency chosen and config 11 or select 1x.
// - Fast ready flag set only while fast oscillator runs and is usable.
// - Fast stable flag set once fast oscillator is within 0.5 percent.
// - Slow oscillator on for 000x with select 1x, or power-up/watchdog need.
// - Slow oscillator is time base of power-up and watchdog timers always.
// - Slow ready flag set only while slow oscillator runs and is usable.
// - Every reset loads frequency select 0111, 500 kHz; software may change it.
// - Postscaler and mux give 16 MHz down to 31.25 kHz, plus 31 kHz.
// - Target oscillator shut down: run its start-up delay before handover.
// - Wait current clock falling edge, hold low, then new clock rising edge.
// - Status flags update only after the new clock is active.
// - Status shows running state of both internal oscillators.
// - Frequency change within same internal oscillator has no start-up delay.
// - Slow target takes one cycle of each clock; external target takes 2 cycles.
// - Secondary target waits 1024 secondary oscillator cycles before takeover.
// - Slow oscillator stops after slow-to-fast switch unless watchdog or power-up timer needs it.
// - Select 00 configured, 01 secondary, 1x internal; cleared on reset.
// - Frequency field decode: 000x slow, 001x to 1111 postscaled fast outputs.
`ifndef CLK_SRC_SEL_REGS_VH
`define CLK_SRC_SEL_REGS_VH
`define CFG_INTERNAL 2'h0
`define CFG_EXT_LOW 2'h1
`define CFG_EXT_MED 2'h2
`define CFG_EXT_HIGH 2'h3
`define SEL_CONFIGURED 2'h0
`define SEL_SECONDARY 2'h1
`define FREQ_RESET 4'h7
`define SRC_EXT 2'h0
`define SRC_SEC 2'h1
`define SRC_SLOW 2'h2
`define SRC_FAST 2'h3
`define CLK_PERIOD_NS 5
`define FAST_START_NS 2000
`define FAST_STABLE_NS 4000
`define FAST_START_CYC ((`FAST_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_STABLE_CYC ((`FAST_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_SWITCH_EDGES 2'h2
`define SEC_SWITCH_EDGES 11'h400
`define ST_RUN 4'h1
`define ST_START 4'h2
`define ST_FALL 4'h4
`define ST_LOW 4'h8
`endif

// ===== clk_src_sel_chk.sv
// Port assertions for the clock source selector
module clk_src_sel_chk (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic ctrl_wr, // Write strobe
  input wire logic [3:0] wr_freq_sel, // Written frequency
  input wire logic [1:0] wr_clk_sel, // Written select
  input wire logic watchdog_enable, // Watchdog need
  input wire logic clock_out_pin_select, // Pin mode
  input wire logic ext_clock_in_pin, // Source
  input wire logic crystal_osc_in, // Source
  input wire logic slow_osc_in, // Source
  input wire logic fast_osc_in, // Source
  input wire logic sys_clk_q, // System clock
  input wire logic slow_osc_enable_q, // Slow request
  input wire logic [3:0] internal_freq_select_q, // Readback
  input wire logic [1:0] sys_clk_select_field_q, // Readback
  input wire logic fast_osc_ready_flag_q, // Flag
  input wire logic fast_osc_stable_flag_q, // Flag
  input wire logic switch_busy_q, // Switch pending
  input wire logic clock_out_pin_oe // Pin enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_freq_reset;
    disable iff (1'b0) reset |=> internal_freq_select_q == 4'h7;
  endproperty
  a_freq_reset: assert property (p_freq_reset) else $error("frequency select not 0111 after reset");
  property p_sel_reset;
    disable iff (1'b0) reset |=> sys_clk_select_field_q == 2'h0;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("clock select not cleared by reset");
  property p_write;
    ctrl_wr |=> internal_freq_select_q == $past(wr_freq_sel) && sys_clk_select_field_q == $past(wr_clk_sel);
  endproperty
  a_write: assert property (p_write) else $error("written fields not read back");
  property p_flag_after;
    $rose(fast_osc_ready_flag_q) |-> !switch_busy_q && !$past(switch_busy_q);
  endproperty
  a_flag_after: assert property (p_flag_after) else $error("status changed during a switch");
  property p_stable;
    fast_osc_stable_flag_q |-> fast_osc_ready_flag_q;
  endproperty
  a_stable: assert property (p_stable) else $error("stable flag without ready flag");
  property p_oe;
    clock_out_pin_select [*3] |-> clock_out_pin_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("clock output pin not driven");
  property p_wdt;
    watchdog_enable [*4] |-> slow_osc_enable_q;
  endproperty
  a_wdt: assert property (p_wdt) else $error("slow oscillator off while watchdog needs it");
  property p_end;
    // A rewrite back to the running source cancels the switch with no high edge
    $fell(switch_busy_q) && !$past(ctrl_wr, 2) |-> sys_clk_q;
  endproperty
  a_end: assert property (p_end) else $error("switch ended without a new clock high");
  property p_static;
    ($stable(ext_clock_in_pin) && $stable(crystal_osc_in) && $stable(slow_osc_in) && $stable(fast_osc_in)
      && !ctrl_wr) [*8] |=> $stable(sys_clk_q);
  endproperty
  a_static: assert property (p_static) else $error("system clock moved with all sources still");
endmodule

// ===== osc_partner.sv
// Far side model: external clock, crystal and both internal oscillators
module osc_partner (
  input wire logic fast_osc_enable, // Run request
  input wire logic slow_osc_enable, // Run request
  input wire logic ext_run, // External clock running
  output logic ext_clock_in_pin, // External clock
  output logic crystal_osc_in, // Crystal output
  output logic slow_osc_in, // Slow oscillator
  output logic fast_osc_in // Fast oscillator
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ext_clock_in_pin = 1'b0;
    crystal_osc_in = 1'b0;
    slow_osc_in = 1'b0;
    fast_osc_in = 1'b0;
  end
  // A stopped external clock holds its level, as a static source would
  always #250 ext_clock_in_pin = ext_run ? ~ext_clock_in_pin : ext_clock_in_pin;
  // Crystal and slow periods are shortened to keep the run short
  always #50 crystal_osc_in = ~crystal_osc_in;
  always #160 slow_osc_in = slow_osc_enable ? ~slow_osc_in : 1'b0;
  always #31.25 fast_osc_in = fast_osc_enable ? ~fast_osc_in : 1'b0;
endmodule

// ===== testbench.sv
// Self-checking bench for the clock source selector
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, ctrl_wr, watchdog_enable, power_up_timer_active, clock_out_pin_select, gpio_out, gpio_oe;
  logic secondary_osc_ready, ext_run, sys_clk_q, fast_osc_enable_q, slow_osc_enable_q, fast_osc_ready_flag_q;
  logic fast_osc_stable_flag_q, slow_osc_ready_flag_q, secondary_osc_ready_flag_q, running_external_q;
  logic switch_busy_q, slow_timebase_q, ext_pin_is_gpio_q, clock_out_pin_o, clock_out_pin_oe;
  logic ext_clock_in_pin, crystal_osc_in, slow_osc_in, fast_osc_in;
  logic [1:0] default_clock_cfg, wr_clk_sel, sys_clk_select_field_q;
  logic [3:0] wr_freq_sel, internal_freq_select_q;
  int fails, cmp_count, cyc;
  logic seen_hi, seen_lo;
  clk_src_sel u_clk_src_sel (.clk, .reset, .default_clock_cfg, .ctrl_wr, .wr_freq_sel, .wr_clk_sel,
    .watchdog_enable, .power_up_timer_active, .clock_out_pin_select, .gpio_out, .gpio_oe,
    .secondary_osc_ready, .ext_clock_in_pin, .crystal_osc_in, .slow_osc_in, .fast_osc_in, .sys_clk_q,
    .fast_osc_enable_q, .slow_osc_enable_q, .internal_freq_select_q, .sys_clk_select_field_q,
    .fast_osc_ready_flag_q, .fast_osc_stable_flag_q, .slow_osc_ready_flag_q, .secondary_osc_ready_flag_q,
    .running_external_q, .switch_busy_q, .slow_timebase_q, .ext_pin_is_gpio_q, .clock_out_pin_o,
    .clock_out_pin_oe);
  osc_partner u_osc_partner (.fast_osc_enable(fast_osc_enable_q), .slow_osc_enable(slow_osc_enable_q),
    .ext_run, .ext_clock_in_pin, .crystal_osc_in, .slow_osc_in, .fast_osc_in);
  task automatic summarize;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Write both fields, then wait for the switch to finish; cyc counts from the taking edge
  task automatic sw(input logic [3:0] f, input logic [1:0] s);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    wr_freq_sel <= f;
    wr_clk_sel <= s;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    wait_n(1);
    chk(internal_freq_select_q, f, "frequency readback");
    chk(sys_clk_select_field_q, s, "select readback");
    wait_n(1);
    chk(switch_busy_q, 1, "switch not started");
    cyc = 2;
    while (switch_busy_q && cyc < 40000)
    begin
      wait_n(1);
      cyc++;
    end
    if (cyc >= 40000)
    begin
      fails++;
      $display("CHECK FAILED at %0t: switch timeout", $time);
      summarize();
    end
    wait_n(3);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    fails = 0;
    cmp_count = 0;
    {reset, ctrl_wr, wr_freq_sel, wr_clk_sel, default_clock_cfg} = {1'b1, 1'b0, 4'h0, 2'h0, 2'h2};
    {watchdog_enable, power_up_timer_active, clock_out_pin_select, gpio_out, gpio_oe} = 5'h03;
    {secondary_osc_ready, ext_run} = 2'h1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    wait_n(1);
    chk(internal_freq_select_q, 4'h7, "frequency after reset");
    chk(sys_clk_select_field_q, 2'h0, "select after reset");
    wait_n(200);
    chk(running_external_q, 1, "not on external clock");
    chk({clock_out_pin_oe, clock_out_pin_o, ext_pin_is_gpio_q}, 3'h6, "pin use on external");
    @(posedge clk);
    ext_run <= 1'b0;
    watchdog_enable <= 1'b1;
    wait_n(150);
    chk(slow_osc_enable_q, 1, "slow off with watchdog");
    {seen_hi, seen_lo} = 2'h0;
    repeat (70)
    begin
      wait_n(1);
      seen_hi |= slow_timebase_q;
      seen_lo |= !slow_timebase_q;
    end
    chk({seen_hi, seen_lo}, 2'h3, "slow time base not toggling");
    @(posedge clk);
    ext_run <= 1'b1;
    watchdog_enable <= 1'b0;
    sw(4'hf, 2'h2);
    chk(cyc >= 400, 1, "fast start-up delay skipped");
    @(posedge clk);
    clock_out_pin_select <= 1'b1;
    wait_n(820);
    chk({fast_osc_ready_flag_q, fast_osc_stable_flag_q, fast_osc_enable_q}, 3'h7, "fast status");
    chk({running_external_q, ext_pin_is_gpio_q}, 2'h1, "pin use on internal");
    sw(4'he, 2'h2);
    chk(cyc < 400, 1, "same source took a start-up delay");
    sw(4'h0, 2'h2);
    wait_n(400);
    chk({slow_osc_enable_q, slow_osc_ready_flag_q, fast_osc_ready_flag_q}, 3'h6, "slow status");
    sw(4'hf, 2'h2);
    chk(slow_osc_enable_q, 0, "slow left on after switch");
    chk(secondary_osc_ready_flag_q, 0, "secondary ready too early");
    @(posedge clk);
    secondary_osc_ready <= 1'b1;
    wait_n(3);
    chk(secondary_osc_ready_flag_q, 1, "secondary not ready");
    // Retarget back to the running source before the secondary count can finish
    @(posedge clk);
    ctrl_wr <= 1'b1;
    wr_freq_sel <= 4'hf;
    wr_clk_sel <= 2'h1;
    @(posedge clk);
    wr_clk_sel <= 2'h2;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    wait_n(4);
    chk(switch_busy_q, 0, "rewrite to current source left a switch pending");
    sw(4'hf, 2'h1);
    chk(cyc >= 20400, 1, "secondary handover too early");
    sw(4'h7, 2'h0);
    chk(running_external_q, 1, "not back on external");
    // Mid-run resets with the internal and the high-power external default
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      default_clock_cfg <= i ? 2'h3 : 2'h0;
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      wait_n(5);
      chk({running_external_q, ext_pin_is_gpio_q, fast_osc_enable_q}, i ? 3'h5 : 3'h3, "default source");
      chk(sys_clk_select_field_q, 2'h0, "select after mid-run reset");
    end
    summarize();
  end
endmodule
bind clk_src_sel clk_src_sel_chk u_clk_src_sel_chk (.clk, .reset, .ctrl_wr, .wr_freq_sel, .wr_clk_sel,
  .watchdog_enable, .clock_out_pin_select, .ext_clock_in_pin, .crystal_osc_in, .slow_osc_in, .fast_osc_in,
  .sys_clk_q, .slow_osc_enable_q, .internal_freq_select_q, .sys_clk_select_field_q, .fast_osc_ready_flag_q,
  .fast_osc_stable_flag_q, .switch_busy_q, .clock_out_pin_oe);
